// >>> src/sbtc_consts.svh
`ifndef SBTC_CONSTS_SVH
`define SBTC_CONSTS_SVH

// Register byte offsets
`define SBTC_OFS_CTRL 12'h000
`define SBTC_OFS_CNT_LO 12'h004
`define SBTC_OFS_CNT_HI 12'h008
`define SBTC_OFS_CC0 12'h00C
`define SBTC_OFS_CC1 12'h010
`define SBTC_OFS_CC2 12'h014
`define SBTC_OFS_CHCTL0 12'h018
`define SBTC_OFS_CHCTL1 12'h01C
`define SBTC_OFS_CHCTL2 12'h020
`define SBTC_OFS_STATUS 12'h024
`define SBTC_OFS_MASK 12'h028

// Control register fields
`define SBTC_CTRL_MODE_LSB 0
`define SBTC_CTRL_PRE_LSB 2
`define SBTC_CTRL_GDIV_LSB 4
`define SBTC_CTRL_RC_BIT 7
`define SBTC_CTRL_IRQEN_BIT 8

// Channel control fields
`define SBTC_CHCTL_CAP_BIT 0
`define SBTC_CHCTL_SEL_LSB 1

// Status and mask layout
`define SBTC_ST_OVF 0
`define SBTC_ST_CH0 1
`define SBTC_ST_COMMON 4

// Reset values
`define SBTC_CTRL_RST 9'h000
`define SBTC_CNT_RST 16'h0000
`define SBTC_HI_RST 8'h00
`define SBTC_CC_RST 16'h0000
`define SBTC_CHCTL_RST 3'h0
`define SBTC_STATUS_RST 5'h00
`define SBTC_MASK_RST 5'h00

// Counter values and prescale masks
`define SBTC_CNT_ZERO 16'h0000
`define SBTC_CNT_ONE 16'h0001
`define SBTC_CNT_TOP 16'hFFFF
`define SBTC_PRE_MASK_1 7'h00
`define SBTC_PRE_MASK_8 7'h07
`define SBTC_PRE_MASK_32 7'h1F
`define SBTC_PRE_MASK_128 7'h7F

`endif

// >>> src/sbtc_pkg.sv
package sbtc_pkg;

  typedef enum logic [1:0] {
    SBTC_HALT = 2'h0,
    SBTC_FREE = 2'h1,
    SBTC_MODULO = 2'h2,
    SBTC_UPDOWN = 2'h3
  } sbtc_mode_e;

  typedef struct packed {
    logic [8:0] ctrl;
    logic [15:0] cnt;
    logic [7:0] hi_buf;
    logic dir_down;
    logic [2:0][15:0] cc;
    logic [2:0][2:0] chctl;
    logic [4:0] status;
    logic [4:0] mask;
    logic [6:0] gdiv;
    logic [6:0] pdiv;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pin_out;
    logic [2:0] dma;
    logic [31:0] rdata;
    logic slverr;
  } sbtc_state_s;

endpackage : sbtc_pkg

// >>> src/sbtc_core.sv
`timescale 1ns/1ns
`include "sbtc_consts.svh"
module sbtc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] ch_in,
  output logic [2:0] ch_out,
  output logic [2:0] ch_oe,
  output logic [2:0] dma_trig,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and decoded control

  sbtc_pkg::sbtc_state_s s_ff;
  sbtc_pkg::sbtc_state_s nxt_s;

  sbtc_pkg::sbtc_mode_e mode;
  logic running;
  logic [2:0] gsel;
  logic [6:0] gmask;
  logic [6:0] pmask;
  logic tick_g;
  logic tick;
  logic free_top;
  logic mod_top;
  logic ud_zero;
  logic ovf_ev;
  logic [2:0] cap_ev;
  logic [2:0] cmp_ev;
  logic [4:0] st_set;
  logic setup;
  logic access;
  logic cnt_clear;

  assign mode = sbtc_pkg::sbtc_mode_e'(s_ff.ctrl[`SBTC_CTRL_MODE_LSB +: 2]);
  assign running = (mode != sbtc_pkg::SBTC_HALT);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign cnt_clear = access & pwrite & (paddr == `SBTC_OFS_CNT_LO);

  ////////////////////////////////////////////////////////////////////////////////
  // Tick generation

  // RC source runs the system at half the crystal rate, so division 1 is barred
  always_comb
  begin
    gsel = s_ff.ctrl[`SBTC_CTRL_GDIV_LSB +: 3];
    if (s_ff.ctrl[`SBTC_CTRL_RC_BIT] && (gsel == 3'h0))
    begin
      gsel = 3'h1;
    end
  end

  assign gmask = ~(7'h7F << gsel);
  assign tick_g = ((s_ff.gdiv & gmask) == gmask);

  always_comb
  begin
    case (s_ff.ctrl[`SBTC_CTRL_PRE_LSB +: 2])
      2'h0: pmask = `SBTC_PRE_MASK_1;
      2'h1: pmask = `SBTC_PRE_MASK_8;
      2'h2: pmask = `SBTC_PRE_MASK_32;
      2'h3: pmask = `SBTC_PRE_MASK_128;
      default: pmask = `SBTC_PRE_MASK_1;
    endcase
  end

  assign tick = tick_g & ((s_ff.pdiv & pmask) == pmask) & running;

  ////////////////////////////////////////////////////////////////////////////////
  // Terminal count events

  assign free_top = (mode == sbtc_pkg::SBTC_FREE) && (s_ff.cnt == `SBTC_CNT_TOP);
  assign mod_top = (mode == sbtc_pkg::SBTC_MODULO) && (s_ff.cnt == s_ff.cc[0]);
  // Next step lands on zero, whether already falling or turning at a tiny compare
  assign ud_zero = (mode == sbtc_pkg::SBTC_UPDOWN) && (s_ff.cnt == `SBTC_CNT_ONE)
                   && (s_ff.dir_down || (s_ff.cnt >= s_ff.cc[0]));
  assign ovf_ev = tick & ~cnt_clear & (free_top | mod_top | ud_zero);

  ////////////////////////////////////////////////////////////////////////////////
  // Channels

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ch
      logic rise;
      logic fall;
      logic cap_mode;
      logic [1:0] sel;
      logic hit;
      assign rise = s_ff.sync2[gi] & ~s_ff.sync3[gi];
      assign fall = ~s_ff.sync2[gi] & s_ff.sync3[gi];
      assign cap_mode = s_ff.chctl[gi][`SBTC_CHCTL_CAP_BIT];
      assign sel = s_ff.chctl[gi][`SBTC_CHCTL_SEL_LSB +: 2];
      // Channel 0 in up/down mode flags at zero, as its compare sets the top
      if (gi == 0)
      begin : g_hit0
        assign hit = (mode == sbtc_pkg::SBTC_UPDOWN) ? ud_zero : (s_ff.cnt == s_ff.cc[gi]);
      end
      else
      begin : g_hitn
        assign hit = (s_ff.cnt == s_ff.cc[gi]);
      end
      assign cap_ev[gi] = running & cap_mode & ((sel[0] & rise) | (sel[1] & fall));
      assign cmp_ev[gi] = tick & ~cap_mode & hit;
    end
  endgenerate

  assign st_set[`SBTC_ST_OVF] = ovf_ev;
  assign st_set[`SBTC_ST_CH0 +: 3] = cap_ev | cmp_ev;
  assign st_set[`SBTC_ST_COMMON] = ovf_ev | (|(cap_ev | cmp_ev));

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb
  begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic mapped;
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    mapped = 1'b1;
    nxt_s = s_ff;
    nxt_s.gdiv = s_ff.gdiv + 7'h01;
    if (tick_g)
    begin
      nxt_s.pdiv = s_ff.pdiv + 7'h01;
    end
    // Pins pass two flops before edge detection reads them
    nxt_s.sync1 = ch_in;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.sync3 = s_ff.sync2;
    nxt_s.dma = cmp_ev;

    if (tick)
    begin
      case (mode)
        sbtc_pkg::SBTC_FREE:
        begin
          nxt_s.cnt = s_ff.cnt + `SBTC_CNT_ONE;
        end
        sbtc_pkg::SBTC_MODULO:
        begin
          if (mod_top)
          begin
            nxt_s.cnt = `SBTC_CNT_ZERO;
          end
          else
          begin
            nxt_s.cnt = s_ff.cnt + `SBTC_CNT_ONE;
          end
        end
        sbtc_pkg::SBTC_UPDOWN:
        begin
          if (!s_ff.dir_down)
          begin
            if ((s_ff.cnt >= s_ff.cc[0]) && (s_ff.cnt != `SBTC_CNT_ZERO))
            begin
              nxt_s.dir_down = 1'b1;
              nxt_s.cnt = s_ff.cnt - `SBTC_CNT_ONE;
            end
            else
            begin
              nxt_s.cnt = s_ff.cnt + `SBTC_CNT_ONE;
            end
          end
          else if (s_ff.cnt <= `SBTC_CNT_ONE)
          begin
            nxt_s.dir_down = 1'b0;
            nxt_s.cnt = `SBTC_CNT_ZERO;
          end
          else
          begin
            nxt_s.cnt = s_ff.cnt - `SBTC_CNT_ONE;
          end
        end
        default:
        begin
          nxt_s.cnt = s_ff.cnt;
        end
      endcase
    end

    for (int i = 0; i < 3; i++)
    begin
      if (cap_ev[i])
      begin
        nxt_s.cc[i] = s_ff.cnt;
      end
      if (cmp_ev[i])
      begin
        case (s_ff.chctl[i][`SBTC_CHCTL_SEL_LSB +: 2])
          2'h0: nxt_s.pin_out[i] = 1'b1;
          2'h1: nxt_s.pin_out[i] = 1'b0;
          2'h2: nxt_s.pin_out[i] = ~s_ff.pin_out[i];
          default: nxt_s.pin_out[i] = s_ff.pin_out[i];
        endcase
      end
    end

    // Read data is sampled at setup; the read clears only the bits it showed,
    // so an event landing between setup and access is kept
    if (access && !pwrite && (paddr == `SBTC_OFS_STATUS))
    begin
      nxt_s.status = s_ff.status & ~s_ff.rdata[4:0];
    end
    nxt_s.status = nxt_s.status | st_set;

    case (paddr)
      `SBTC_OFS_CTRL: rd = {23'h000000, s_ff.ctrl};
      `SBTC_OFS_CNT_LO: rd = {24'h000000, s_ff.cnt[7:0]};
      `SBTC_OFS_CNT_HI: rd = {24'h000000, s_ff.hi_buf};
      `SBTC_OFS_CC0: rd = {16'h0000, s_ff.cc[0]};
      `SBTC_OFS_CC1: rd = {16'h0000, s_ff.cc[1]};
      `SBTC_OFS_CC2: rd = {16'h0000, s_ff.cc[2]};
      `SBTC_OFS_CHCTL0: rd = {29'h00000000, s_ff.chctl[0]};
      `SBTC_OFS_CHCTL1: rd = {29'h00000000, s_ff.chctl[1]};
      `SBTC_OFS_CHCTL2: rd = {29'h00000000, s_ff.chctl[2]};
      `SBTC_OFS_STATUS: rd = {27'h0000000, s_ff.status};
      `SBTC_OFS_MASK: rd = {27'h0000000, s_ff.mask};
      default: mapped = 1'b0;
    endcase

    if (setup)
    begin
      nxt_s.rdata = pwrite ? 32'h0000_0000 : rd;
      nxt_s.slverr = ~mapped;
      if (!pwrite && (paddr == `SBTC_OFS_CNT_LO))
      begin
        nxt_s.hi_buf = s_ff.cnt[15:8];
      end
    end

    if (access && pwrite)
    begin
      case (paddr)
        `SBTC_OFS_CTRL:
        begin
          wv = merge({23'h000000, s_ff.ctrl}, pwdata, pstrb);
          nxt_s.ctrl = wv[8:0];
        end
        `SBTC_OFS_CC0, `SBTC_OFS_CC1, `SBTC_OFS_CC2:
        begin
          wv = merge({16'h0000, s_ff.cc[paddr[4:2] - 3'h3]}, pwdata, pstrb);
          nxt_s.cc[paddr[4:2] - 3'h3] = wv[15:0];
        end
        `SBTC_OFS_CHCTL0, `SBTC_OFS_CHCTL1, `SBTC_OFS_CHCTL2:
        begin
          wv = merge({29'h00000000, s_ff.chctl[paddr[4:2] - 3'h6]}, pwdata, pstrb);
          nxt_s.chctl[paddr[4:2] - 3'h6] = wv[2:0];
        end
        `SBTC_OFS_MASK:
        begin
          wv = merge({27'h0000000, s_ff.mask}, pwdata, pstrb);
          nxt_s.mask = wv[4:0];
        end
        default:
        begin
          wv = 32'h0000_0000;
        end
      endcase
    end

    // Clearing write beats a tick in the same cycle
    if (cnt_clear)
    begin
      nxt_s.cnt = `SBTC_CNT_ZERO;
      nxt_s.dir_down = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff <= '0;
      s_ff.ctrl <= `SBTC_CTRL_RST;
      s_ff.cnt <= `SBTC_CNT_RST;
      s_ff.hi_buf <= `SBTC_HI_RST;
      s_ff.cc <= {3{`SBTC_CC_RST}};
      s_ff.chctl <= {3{`SBTC_CHCTL_RST}};
      s_ff.status <= `SBTC_STATUS_RST;
      s_ff.mask <= `SBTC_MASK_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = access & s_ff.slverr;
  assign ch_out = s_ff.pin_out;
  assign ch_oe = ~{s_ff.chctl[2][0], s_ff.chctl[1][0], s_ff.chctl[0][0]};
  assign dma_trig = s_ff.dma;
  // Masked flags only reach the line while the interrupt enable bit is set
  assign irq = s_ff.ctrl[`SBTC_CTRL_IRQEN_BIT] & (|(s_ff.status & s_ff.mask));

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cnt_clear: assert property (cnt_clear |=> s_ff.cnt == `SBTC_CNT_ZERO)
    else $error("counter not cleared by low-byte write");
  a_halt_hold: assert property (!running && !cnt_clear |=> s_ff.cnt == $past(s_ff.cnt))
    else $error("halted counter moved");
  a_free_step: assert property (tick && !cnt_clear && mode == sbtc_pkg::SBTC_FREE
    |=> s_ff.cnt == $past(s_ff.cnt) + `SBTC_CNT_ONE)
    else $error("free-running counter did not step by one");
  a_free_wrap: assert property (tick && !cnt_clear && free_top
    |=> s_ff.cnt == `SBTC_CNT_ZERO && s_ff.status[`SBTC_ST_OVF] && s_ff.status[`SBTC_ST_COMMON])
    else $error("free-running wrap or flags wrong");
  a_mod_wrap: assert property (tick && !cnt_clear && mod_top
    |=> s_ff.cnt == `SBTC_CNT_ZERO && s_ff.status[`SBTC_ST_COMMON])
    else $error("modulo wrap wrong");
  a_ud_turn: assert property (tick && !cnt_clear && mode == sbtc_pkg::SBTC_UPDOWN
    && !s_ff.dir_down && s_ff.cnt >= s_ff.cc[0] && s_ff.cnt > `SBTC_CNT_ONE
    |=> s_ff.dir_down && s_ff.cnt == $past(s_ff.cnt) - `SBTC_CNT_ONE)
    else $error("up/down did not turn at compare");
  a_ud_zero: assert property (ovf_ev && mode == sbtc_pkg::SBTC_UPDOWN
    |=> s_ff.cnt == `SBTC_CNT_ZERO ##0 s_ff.status[`SBTC_ST_OVF])
    else $error("up/down zero arrival not flagged");
  a_irq_gate: assert property (ovf_ev && s_ff.mask[`SBTC_ST_OVF] && !access
    && s_ff.ctrl[`SBTC_CTRL_IRQEN_BIT] |=> irq)
    else $error("enabled overflow did not raise interrupt");
  a_hi_buffer: assert property (setup && !pwrite && paddr == `SBTC_OFS_CNT_LO
    |=> s_ff.hi_buf == $past(s_ff.cnt[15:8]) && s_ff.rdata[7:0] == $past(s_ff.cnt[7:0]))
    else $error("high byte not buffered with low-byte read");
  a_dma_cmp: assert property (cmp_ev[1] |=> dma_trig[1] && s_ff.status[`SBTC_ST_CH0 + 1])
    else $error("compare event missed dma trigger or flag");

  c_free_wrap: cover property (tick && free_top);
  c_mod_wrap: cover property (tick && mod_top);
  c_ud_zero: cover property (ovf_ev && mode == sbtc_pkg::SBTC_UPDOWN);
  c_capture: cover property (|cap_ev);

endmodule : sbtc_core

// >>> testbench/sbtc_core_tb.sv
`timescale 1ns/1ns
`include "sbtc_consts.svh"
module sbtc_core_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] ch_in = 3'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] ch_out;
  logic [2:0] ch_oe;
  logic [2:0] dma_trig;
  logic irq;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int dma_n = 0;
  integer seed = 74;
  logic [31:0] rd_q;
  logic err_q;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [1:0] m;
  int r1;
  int t;
  int pre_t[7] = '{0, 1, 2, 3, 0, 0, 1};
  int n_t[7] = '{0, 0, 0, 0, 0, 2, 1};
  int rc_t[7] = '{0, 0, 0, 0, 1, 0, 1};

  sbtc_core sbtc_core_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ch_in(ch_in),
    .ch_out(ch_out),
    .ch_oe(ch_oe),
    .dma_trig(dma_trig),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #25 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  always @(posedge pclk) if (dma_trig[2] === 1'b1) dma_n <= dma_n + 1;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctrl(input logic [1:0] md, input int pre, input int n,
    input int rc, input int en);
    return {23'h0, en[0], rc[0], n[2:0], pre[1:0], md};
  endfunction : ctrl

  // Ticks per counter step: global divide, RC source floor, local prescale
  function automatic int ratio(input int pre, input int n, input int rc);
    int g;
    g = (rc != 0 && n == 0) ? 2 : (1 << n);
    return g * (1 << (pre == 0 ? 0 : 2 * pre + 1));
  endfunction : ratio

  function automatic int period(input logic [1:0] md, input int top);
    return (md == sbtc_pkg::SBTC_UPDOWN) ? 2 * top : top + 1;
  endfunction : period

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Phase of the tick divider is unknown, so counts get a small window
  task automatic chk_near(input string nm, input int exp, input logic [31:0] got, input int tol);
    checks++;
    if ((^got) === 1'bx || int'(got) < exp - tol || int'(got) > exp + tol)
    begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_near

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp,
    input logic [31:0] msk);
    rd(a);
    chk(nm, exp, rd_q & msk);
  endtask : rdchk

  // Low byte first so that the buffered high byte matches it
  task automatic read_cnt(output logic [15:0] v);
    rd(`SBTC_OFS_CNT_LO);
    v[7:0] = rd_q[7:0];
    rd(`SBTC_OFS_CNT_HI);
    v[15:8] = rd_q[7:0];
  endtask : read_cnt

  task automatic wait_rise(input int lim);
    int n;
    n = 0;
    while (irq === 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      give_verdict();
    end
  endtask : wait_rise

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("ctrl reset", `SBTC_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rdchk("cnt lo reset", `SBTC_OFS_CNT_LO, 32'h0, 32'hFFFFFFFF);
    rdchk("cnt hi reset", `SBTC_OFS_CNT_HI, 32'h0, 32'hFFFFFFFF);
    rdchk("status reset", `SBTC_OFS_STATUS, 32'h0, 32'hFFFFFFFF);
    rdchk("unmapped data", 12'h02C, 32'h0, 32'hFFFFFFFF);
    chk("unmapped error", 1'b1, err_q);
    for (int i = 0; i < 7; i++)
    begin
      wr(`SBTC_OFS_CNT_LO, 32'h0);
      wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_FREE, pre_t[i], n_t[i], rc_t[i], 0));
      repeat (1024) @(posedge pclk);
      wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_HALT, pre_t[i], n_t[i], rc_t[i], 0));
      read_cnt(v1);
      r1 = 1024 / ratio(pre_t[i], n_t[i], rc_t[i]);
      chk_near("tick count", r1, v1, 3);
      repeat (40) @(posedge pclk);
      read_cnt(v2);
      chk("halted count", v1, v2);
    end
    wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_FREE, 0, 0, 0, 0));
    repeat (600) @(posedge pclk);
    rdchk("stale high byte", `SBTC_OFS_CNT_HI, v1[15:8], 32'hFF);
    wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_HALT, 0, 0, 0, 0));
    read_cnt(v2);
    chk_near("coherent count", 606, v2 - v1, 6);
    apb(1'b1, `SBTC_OFS_CNT_LO, $random(seed), 4'(($random(seed))));
    read_cnt(v2);
    chk("cleared count", 32'h0, v2);
    // Interrupt needs both the overflow mask and the interrupt enable bit
    wr(`SBTC_OFS_CC0, 32'h14);
    for (int k = 0; k < 4; k++)
    begin
      wr(`SBTC_OFS_MASK, 32'(k & 1));
      wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_MODULO, 0, 0, 0, k >> 1));
      rd(`SBTC_OFS_STATUS);
      repeat (60) @(posedge pclk);
      chk("irq gating", 1'(k == 3), irq);
    end
    r1 = dma_n;
    repeat (210) @(posedge pclk);
    chk_near("dma pulses", 10, dma_n - r1, 1);
    chk("compare pin set", 1'b1, ch_out[2]);
    wr(`SBTC_OFS_CHCTL2, 32'h2);
    repeat (30) @(posedge pclk);
    chk("compare pin clear", 1'b0, ch_out[2]);
    for (int j = 0; j < 4; j++)
    begin
      m = (j < 2) ? sbtc_pkg::SBTC_MODULO : sbtc_pkg::SBTC_UPDOWN;
      t = 8 + ({$random(seed)} % 56);
      wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_HALT, 0, 0, 0, 1));
      wr(`SBTC_OFS_CC0, 32'(t));
      wr(`SBTC_OFS_CNT_LO, 32'h0);
      wr(`SBTC_OFS_CTRL, ctrl(m, 0, 0, 0, 1));
      rd(`SBTC_OFS_STATUS);
      wait_rise(300);
      r1 = cyc;
      rd(`SBTC_OFS_STATUS);
      wait_rise(300);
      chk("flag period", period(m, t), cyc - r1);
    end
    wr(`SBTC_OFS_CHCTL1, 32'h3);
    @(posedge pclk);
    chk("capture pin drive", 2'b10, ch_oe[2:1]);
    rd(`SBTC_OFS_STATUS);
    ch_in <= 3'h2;
    repeat (6) @(posedge pclk);
    rdchk("capture flag", `SBTC_OFS_STATUS, 32'h4, 32'h4);
    // Free wrap takes 65536 ticks, so it runs last at full tick rate
    wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_HALT, 0, 0, 0, 1));
    wr(`SBTC_OFS_CNT_LO, 32'h0);
    wr(`SBTC_OFS_MASK, 32'h1);
    // Channels kept quiet so only the wrap can raise the common flag
    wr(`SBTC_OFS_CHCTL0, 32'h1);
    wr(`SBTC_OFS_CHCTL2, 32'h1);
    wr(`SBTC_OFS_CTRL, ctrl(sbtc_pkg::SBTC_FREE, 0, 0, 0, 1));
    r1 = cyc;
    rd(`SBTC_OFS_STATUS);
    wait_rise(70000);
    chk_near("wrap time", 65538, cyc - r1, 4);
    rdchk("wrap flags", `SBTC_OFS_STATUS, 32'h11, 32'h11);
    rdchk("flag cleared", `SBTC_OFS_STATUS, 32'h0, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 1'b0, irq);
    give_verdict();
  end
endmodule : sbtc_core_tb
